// [logic/pps_cfg.svh]
// Constants for the port priority shutdown block.
// Assumes a 50 MHz core clock; included by the package only, and the design uses its macros.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

`define PPS_NUM_PORTS 8
`define PPS_CLK_PERIOD_NS 20
`define PPS_SHUTDOWN_REQUEST_N_MIN_NS 5000
// Least time, so the cycle count rounds up
`define PPS_SHUTDOWN_REQUEST_N_MIN_CYC \
    ((`PPS_SHUTDOWN_REQUEST_N_MIN_NS + `PPS_CLK_PERIOD_NS - 1) / `PPS_CLK_PERIOD_NS)
`define PPS_CNT_W 9
`define PPS_EN_RST 8'h00

`endif

// [logic/pps_pkg.sv]
// Types shared by the port priority shutdown block and its bench.
// Assumes pps_cfg.svh is on the include path.
`include "pps_cfg.svh"

package pps_pkg;

    typedef logic [`PPS_NUM_PORTS-1:0] pps_mask_t;

    // Per-port detect and classify enables, one bit per port
    typedef struct packed {
        pps_mask_t detect;
        pps_mask_t classify;
    } pps_en_t;

endpackage

// [logic/pps_shutdown.sv]
// Priority-based emergency shutdown of the eight PSE ports.
// Assumes all inputs are synchronous to clk, except shutdown_request_n,
// which may come straight from a pin and is synchronised here.

`timescale 1ns/1ns

module pps_shutdown
    import pps_pkg::*;
#(
    parameter int unsigned CNT_W = `PPS_CNT_W,
    parameter logic [CNT_W-1:0] MIN_CYC =
        CNT_W'(`PPS_SHUTDOWN_REQUEST_N_MIN_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shutdown_request_n,
    input wire pps_mask_t port_low_prio,
    input wire pps_mask_t port_on,
    input wire logic en_wr,
    input wire pps_en_t en_wr_data,
    output pps_en_t en_state,
    output pps_mask_t port_force_off,
    output pps_mask_t port_shut,
    output logic shutdown_active
);

    logic sync1_reg;
    logic sync2_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic active_reg;
    logic active_next;
    pps_mask_t force_off_reg;
    pps_mask_t shut_reg;
    pps_en_t en_reg;
    pps_en_t en_next;

    // Host write, then hardware clear of low-priority ports on top
    function automatic pps_mask_t en_update(
        input pps_mask_t cur,
        input pps_mask_t wdata,
        input logic wr,
        input logic clr,
        input pps_mask_t low
    );
        pps_mask_t v;
        v = wr ? wdata : cur;
        if (clr) begin
            v = v & ~low;
        end
        return v;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= shutdown_request_n;
            sync2_reg <= sync1_reg;
        end
    end

    always_comb begin
        if (sync2_reg) begin
            cnt_next = '0;
        end else if (cnt_reg == MIN_CYC) begin
            cnt_next = cnt_reg;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
        active_next = (cnt_next == MIN_CYC);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
        end
    end

    // bit set means low priority
    // Live priority is used so a port demoted mid-shutdown is also held off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_off_reg <= '0;
        end else if (active_next) begin
            force_off_reg <= port_low_prio;
        end else begin
            force_off_reg <= '0;
        end
    end

    // only powered ports
    // Record which ports were switched off when this shutdown qualified
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_reg <= '0;
        end else if (active_next && !active_reg) begin
            shut_reg <= port_low_prio & port_on;
        end else if (!active_next) begin
            shut_reg <= '0;
        end
    end

    // high priority kept
    // Clear wins over a host write so enables cannot return mid-shutdown
    always_comb begin
        en_next.detect = en_update(en_reg.detect, en_wr_data.detect,
            en_wr, active_next, port_low_prio);
        en_next.classify = en_update(en_reg.classify,
            en_wr_data.classify, en_wr, active_next, port_low_prio);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg.detect <= `PPS_EN_RST;
            en_reg.classify <= `PPS_EN_RST;
        end else begin
            en_reg <= en_next;
        end
    end

    assign en_state = en_reg;
    assign port_force_off = force_off_reg;
    assign port_shut = shut_reg;
    assign shutdown_active = active_reg;

    property p_qualify;
        @(posedge clk) disable iff (!rst_n)
        $rose(active_reg) |-> $past(cnt_reg) == MIN_CYC - 1'b1;
    endproperty
    a_qualify: assert property (p_qualify)
        else $error("shutdown qualified before the minimum low time");

    property p_turn_off;
        @(posedge clk) disable iff (!rst_n)
        $rose(active_reg) |-> force_off_reg == $past(port_low_prio);
    endproperty
    a_turn_off: assert property (p_turn_off)
        else $error("low-priority ports not forced off at shutdown");

    property p_untouched;
        @(posedge clk) disable iff (!rst_n)
        $rose(active_reg) |->
            shut_reg == ($past(port_on) & $past(port_low_prio));
    endproperty
    a_untouched: assert property (p_untouched)
        else $error("shut mask does not match powered low-priority ports");

    property p_high_kept;
        @(posedge clk) disable iff (!rst_n)
        ##1 (force_off_reg & ~$past(port_low_prio)) == '0;
    endproperty
    a_high_kept: assert property (p_high_kept)
        else $error("high-priority port was forced off");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        active_reg ##1 active_reg |-> force_off_reg == $past(port_low_prio);
    endproperty
    a_hold: assert property (p_hold)
        else $error("low-priority port released during shutdown");

    property p_no_force_idle;
        @(posedge clk) disable iff (!rst_n)
        !active_reg |-> force_off_reg == '0 && shut_reg == '0;
    endproperty
    a_no_force_idle: assert property (p_no_force_idle)
        else $error("port forced off without a shutdown");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        active_reg |->
            ((en_reg.detect | en_reg.classify) & $past(port_low_prio)) == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("enable of low-priority port survived shutdown");

    property p_keep;
        @(posedge clk) disable iff (!rst_n)
        !en_wr && !active_next |=> $stable(en_reg);
    endproperty
    a_keep: assert property (p_keep)
        else $error("enables changed with no write and no shutdown");

    property p_release;
        @(posedge clk) disable iff (!rst_n)
        sync2_reg |=> !active_reg;
    endproperty
    a_release: assert property (p_release)
        else $error("shutdown active after the input returned high");

    property p_short_pulse;
        @(posedge clk) disable iff (!rst_n)
        !active_reg && cnt_reg < MIN_CYC - 1'b1 |=> !active_reg;
    endproperty
    a_short_pulse: assert property (p_short_pulse)
        else $error("short low pulse triggered a shutdown");

endmodule

// [bench/pps_host_model.sv]
// Host and shutdown source facing the port priority shutdown block.
// Assumes the bench calls its tasks and that the clock runs free.
`timescale 1ns/1ns

module pps_host_model
    import pps_pkg::*;
(
    input wire logic clk,
    output logic shutdown_request_n,
    output logic en_wr,
    output pps_en_t en_wr_data
);
    initial begin
        shutdown_request_n = 1'b1;
        en_wr = 1'b0;
        en_wr_data = '0;
    end

    // Level changes only at the falling edge, away from sampling
    task automatic drive_shutdown_request_n(input logic v);
        @(negedge clk);
        shutdown_request_n = v;
    endtask

    task automatic write_en(input pps_en_t d);
        @(negedge clk);
        en_wr = 1'b1;
        en_wr_data = d;
        @(negedge clk);
        en_wr = 1'b0;
        // Stale data is inverted so a late capture shows up
        en_wr_data = ~d;
    endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the port priority shutdown block.
// Assumes a shortened qualify count so the run stays brief.
`timescale 1ns/1ns

module tb;
    import pps_pkg::*;
    localparam logic [8:0] SHORT_MIN = 9'h008;
    logic clk;
    logic rst_n;
    logic shutdown_request_n;
    logic en_wr;
    logic shutdown_active;
    logic seen_active;
    pps_mask_t port_low_prio;
    pps_mask_t port_on;
    pps_mask_t port_force_off;
    pps_mask_t port_shut;
    pps_en_t en_wr_data;
    pps_en_t en_state;
    int fail_count = 0;
    int samples_checked = 0;

    pps_shutdown #(.MIN_CYC(SHORT_MIN)) uut (.clk(clk), .rst_n(rst_n),
        .shutdown_request_n(shutdown_request_n),
        .port_low_prio(port_low_prio), .port_on(port_on),
        .en_wr(en_wr), .en_wr_data(en_wr_data), .en_state(en_state),
        .port_force_off(port_force_off), .port_shut(port_shut),
        .shutdown_active(shutdown_active));

    pps_host_model host (.clk(clk), .shutdown_request_n(shutdown_request_n),
        .en_wr(en_wr), .en_wr_data(en_wr_data));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (shutdown_active === 1'b1) seen_active <= 1'b1;

    task automatic chk(input logic [15:0] got, exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_init;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk({port_force_off, port_shut}, 16'h0000, "reset outputs");
        chk(en_state, 16'h0000, "reset enables");
        host.write_en(16'hffff);
        chk(en_state, 16'hffff, "enable write");
        $display("test init done");
    endtask

    // Seven low samples, one short of qualifying, must leave all alone
    task automatic t_short;
        seen_active = 1'b0;
        host.drive_shutdown_request_n(1'b0);
        repeat (6) @(negedge clk);
        host.drive_shutdown_request_n(1'b1);
        repeat (6) @(negedge clk);
        chk({15'h0, seen_active}, 16'h0000, "short pulse");
        chk(en_state, 16'hffff, "enables kept");
        $display("test short done");
    endtask

    // Qualifies at the edge MIN_CYC plus two sync stages after the fall
    task automatic t_shut;
        host.drive_shutdown_request_n(1'b0);
        repeat (9) @(negedge clk);
        chk({15'h0, shutdown_active}, 16'h0000, "early");
        @(negedge clk);
        chk({15'h0, shutdown_active}, 16'h0001, "active");
        repeat (4) @(negedge clk);
        chk({8'h0, port_force_off}, 16'h000f, "force off");
        chk({8'h0, port_shut}, 16'h0005, "shut set");
        chk(en_state, 16'hf0f0, "enables cleared");
        host.write_en(16'hffff);
        chk(en_state, 16'hf0f0, "write refused");
        port_on = 8'hff;
        port_low_prio = 8'h8f;
        repeat (2) @(negedge clk);
        chk({8'h0, port_force_off}, 16'h008f, "live prio");
        chk({8'h0, port_shut}, 16'h0005, "shut kept");
        repeat (3) @(negedge clk);
        chk({8'h0, port_force_off}, 16'h008f, "held off");
        port_low_prio = 8'h0f;
        host.drive_shutdown_request_n(1'b1);
        repeat (4) @(negedge clk);
        chk({15'h0, shutdown_active}, 16'h0000, "released");
        chk({8'h0, port_force_off}, 16'h0000, "force clear");
        // Port 7 was demoted mid-shutdown, so its enables went too
        chk(en_state, 16'h7070, "not restored");
        host.write_en(16'hffff);
        chk(en_state, 16'hffff, "rewritten");
        $display("test shutdown done");
    endtask

    // Reset in mid-shutdown drops everything at once
    task automatic t_reset;
        host.drive_shutdown_request_n(1'b0);
        repeat (12) @(negedge clk);
        chk({8'h0, port_shut}, 16'h000f, "shut all on");
        rst_n = 1'b0;
        @(negedge clk);
        chk({15'h0, shutdown_active}, 16'h0000, "reset idle");
        chk(en_state, 16'h0000, "reset clears");
        host.drive_shutdown_request_n(1'b1);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({port_force_off, port_shut}, 16'h0000, "after reset");
        port_on = 8'h35;
        host.write_en(16'hffff);
        chk(en_state, 16'hffff, "enable rewrite");
        $display("test reset done");
    endtask

    initial begin
        rst_n = 1'b0;
        port_on = 8'h35;
        port_low_prio = 8'h0f;
        seen_active = 1'b0;
        t_init();
        t_short();
        t_shut();
        t_reset();
        close_out();
    end

    // Tests take about eighty cycles; this is generous
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
